//--- verilog/ctd_consts.vh
`ifndef CTD_CONSTS_VH
`define CTD_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define CTD_ADDR_IRQ1_ROUTE 8'h22
`define CTD_ADDR_CLICK_CFG 8'h38
`define CTD_ADDR_CLICK_SRC 8'h39
`define CTD_ADDR_THRESHOLD 8'h3A
`define CTD_ADDR_TIME_LIMIT 8'h3B
`define CTD_ADDR_QUIET 8'h3C
`define CTD_ADDR_WINDOW 8'h3D
// ****************************************
// Field positions
// ****************************************
`define CTD_BIT_CLICK_IRQ1 7
`define CTD_BIT_GEN1_IRQ1 6
`define CTD_BIT_READY_A_IRQ1 4
`define CTD_BIT_READY_B_IRQ1 3
`define CTD_BIT_FILL_IRQ1 2
`define CTD_BIT_OVFL_IRQ1 1
`define CTD_ROUTE_MASK 8'hDE
`define CTD_CFG_MASK 8'h3F
`define CTD_THS_MASK 8'h7F
// ****************************************
// Reset values
// ****************************************
`define CTD_RST_BYTE 8'h00
`define CTD_RST_CNT 8'h00
`define CTD_CNT_ONE 8'h01
`define CTD_CNT_MAX 8'hFF
`endif

//--- verilog/ctd_click_detector.v
`timescale 1ns/10ps
`include "ctd_consts.vh"

// Function
// - Per-axis click status bits, set on click
// - Threshold resets zero, LSB is fullscale/128
// - Detection starts when an enabled axis rises above threshold
// - Threshold is an unsigned magnitude
// - Click needs fall below within limit
// - Double mode: latency suppresses detection
// - Second click must start within window
// - Gap beyond latency plus window rejected
// - Click routed to pin one when enabled
// - Generator one routed when enabled
// - Two data-ready sources each routable
// - Fill level and overflow flags routable
// - Latched until source read, else latency
// - Second starts on crossing or still above
// - Separate single and double enables per axis
// - Pin one is OR of routed sources
module ctd_click_detector (
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_b_in,
  // Register port
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // Samples, one strobe per output sample
  input wire sample_strobe_in,
  input wire [15:0] axis1_in,
  input wire [15:0] axis2_in,
  input wire [15:0] axis3_in,
  input wire latch_click_interrupt_in,
  // Other interrupt sources
  input wire generator1_irq_in,
  input wire sample_ready_a_in,
  input wire sample_ready_b_in,
  input wire fill_level_flag_in,
  input wire buffer_overflow_flag_in,
  // Interrupt pin and click interrupt
  output reg interrupt_pin_one_out,
  output reg click_irq_out
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_FIRST = 5'h02;
  localparam [4:0] ST_QUIET = 5'h04;
  localparam [4:0] ST_WIN = 5'h08;
  localparam [4:0] ST_SECOND = 5'h10;

  reg [7:0] route_r;
  reg [5:0] cfg_r;
  reg [6:0] ths_r;
  reg [7:0] limit_r;
  reg [7:0] quiet_r;
  reg [7:0] window_r;
  reg [6:0] src_r;
  reg [4:0] st_r;
  reg [4:0] st_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg [2:0] axes_r;
  reg [2:0] prev_hit_r;
  reg sign_r;
  reg irq_hold_r;
  reg [7:0] hold_cnt_r;
  reg single_ev;
  reg double_ev;
  reg timeout_clear;
  wire [14:0] mag1;
  wire [14:0] mag2;
  wire [14:0] mag3;
  wire [2:0] above;
  wire [2:0] en_any;
  wire [2:0] hit;
  wire any_hit;
  wire start_hit;
  wire any_single;
  wire any_double;
  wire hit_sign;
  wire src_read;
  wire [14:0] ths_scaled;

  // ****************************************
  // Threshold compare
  // ****************************************
  // Full 15-bit magnitude; threshold LSB is full scale/128
  assign mag1 = axis1_in[15] ? (~axis1_in[14:0] + 15'h0001)
                              : axis1_in[14:0];
  assign mag2 = axis2_in[15] ? (~axis2_in[14:0] + 15'h0001)
                              : axis2_in[14:0];
  assign mag3 = axis3_in[15] ? (~axis3_in[14:0] + 15'h0001)
                              : axis3_in[14:0];
  assign ths_scaled = {ths_r, 8'h00};
  assign above = {mag3 > ths_scaled, mag2 > ths_scaled,
                  mag1 > ths_scaled};
  assign en_any = {cfg_r[5] | cfg_r[4], cfg_r[3] | cfg_r[2],
                   cfg_r[1] | cfg_r[0]};
  assign hit = above & en_any;
  assign any_hit = |hit;
  // Start needs a rising crossing, not a held level
  assign start_hit = |(hit & ~prev_hit_r);
  assign any_single = |({cfg_r[4], cfg_r[2], cfg_r[0]} & axes_r);
  assign any_double = |({cfg_r[5], cfg_r[3], cfg_r[1]} & axes_r);
  assign hit_sign = hit[0] ? axis1_in[15] :
                    hit[1] ? axis2_in[15] : axis3_in[15];
  assign src_read = reg_rd_in && (reg_addr_in == `CTD_ADDR_CLICK_SRC);

  // ****************************************
  // Click state machine
  // ****************************************
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    single_ev = 1'b0;
    double_ev = 1'b0;
    timeout_clear = 1'b0;
    if (sample_strobe_in) begin
      cnt_nxt = cnt_r + `CTD_CNT_ONE;
      case (st_r)
        ST_IDLE: begin
          cnt_nxt = `CTD_RST_CNT;
          if (start_hit) begin
            st_nxt = ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (!any_hit) begin
            cnt_nxt = `CTD_RST_CNT;
            single_ev = any_single;
            st_nxt = any_double ? ST_QUIET : ST_IDLE;
          end else if (cnt_r >= limit_r) begin
            st_nxt = ST_IDLE;
          end
        end
        ST_QUIET: begin
          if (cnt_r >= quiet_r) begin
            cnt_nxt = `CTD_RST_CNT;
            // Still above at latency end starts second click
            st_nxt = any_hit ? ST_SECOND : ST_WIN;
          end
        end
        ST_WIN: begin
          if (any_hit) begin
            cnt_nxt = `CTD_RST_CNT;
            st_nxt = ST_SECOND;
          end else if (cnt_r >= window_r) begin
            st_nxt = ST_IDLE;
          end
        end
        ST_SECOND: begin
          if (!any_hit) begin
            double_ev = 1'b1;
            st_nxt = ST_IDLE;
          end else if (cnt_r >= limit_r) begin
            st_nxt = ST_IDLE;
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          cnt_nxt = `CTD_RST_CNT;
        end
      endcase
      if (st_nxt == ST_IDLE) begin
        cnt_nxt = `CTD_RST_CNT;
      end
    end
    if (!irq_hold_r || latch_click_interrupt_in) begin
      timeout_clear = 1'b0;
    end else if (sample_strobe_in && hold_cnt_r >= quiet_r) begin
      timeout_clear = 1'b1;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      st_r <= ST_IDLE;
      cnt_r <= `CTD_RST_CNT;
      axes_r <= 3'h0;
      sign_r <= 1'b0;
      prev_hit_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      if (sample_strobe_in) begin
        prev_hit_r <= hit;
      end
      if (sample_strobe_in && any_hit &&
          ((st_r == ST_IDLE && start_hit) || st_r == ST_WIN ||
           (st_r == ST_QUIET && cnt_r >= quiet_r))) begin
        axes_r <= hit;
        sign_r <= hit_sign;
      end
    end
  end

  // ****************************************
  // Click source and interrupt hold
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      src_r <= 7'h00;
      irq_hold_r <= 1'b0;
      hold_cnt_r <= `CTD_RST_CNT;
    end else if (single_ev || double_ev) begin
      // Set wins over a simultaneous read clear
      src_r <= {1'b1, double_ev, single_ev, sign_r,
                axes_r};
      irq_hold_r <= 1'b1;
      hold_cnt_r <= `CTD_RST_CNT;
    end else begin
      if (src_read) begin
        src_r <= 7'h00;
      end
      if (latch_click_interrupt_in) begin
        if (src_read) begin
          irq_hold_r <= 1'b0;
        end
      end else if (timeout_clear) begin
        irq_hold_r <= 1'b0;
      end
      if (sample_strobe_in && hold_cnt_r != `CTD_CNT_MAX) begin
        hold_cnt_r <= hold_cnt_r + `CTD_CNT_ONE;
      end
    end
  end

  // ****************************************
  // Registers and pin
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      route_r <= `CTD_RST_BYTE;
      cfg_r <= 6'h00;
      ths_r <= 7'h00;
      limit_r <= `CTD_RST_BYTE;
      quiet_r <= `CTD_RST_BYTE;
      window_r <= `CTD_RST_BYTE;
      reg_rdata_out <= `CTD_RST_BYTE;
      interrupt_pin_one_out <= 1'b0;
      click_irq_out <= 1'b0;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `CTD_ADDR_IRQ1_ROUTE:
            route_r <= reg_wdata_in & `CTD_ROUTE_MASK;
          `CTD_ADDR_CLICK_CFG: cfg_r <= reg_wdata_in[5:0];
          `CTD_ADDR_THRESHOLD: ths_r <= reg_wdata_in[6:0];
          `CTD_ADDR_TIME_LIMIT: limit_r <= reg_wdata_in;
          `CTD_ADDR_QUIET: quiet_r <= reg_wdata_in;
          `CTD_ADDR_WINDOW: window_r <= reg_wdata_in;
          default: begin
          end
        endcase
      end
      case (reg_addr_in)
        `CTD_ADDR_IRQ1_ROUTE: reg_rdata_out <= route_r;
        `CTD_ADDR_CLICK_CFG: reg_rdata_out <= {2'h0, cfg_r};
        `CTD_ADDR_CLICK_SRC: reg_rdata_out <= {1'b0, src_r};
        `CTD_ADDR_THRESHOLD: reg_rdata_out <= {1'b0, ths_r};
        `CTD_ADDR_TIME_LIMIT: reg_rdata_out <= limit_r;
        `CTD_ADDR_QUIET: reg_rdata_out <= quiet_r;
        `CTD_ADDR_WINDOW: reg_rdata_out <= window_r;
        default: reg_rdata_out <= `CTD_RST_BYTE;
      endcase
      click_irq_out <= irq_hold_r;
      interrupt_pin_one_out <=
        (route_r[`CTD_BIT_CLICK_IRQ1] & irq_hold_r) |
        (route_r[`CTD_BIT_GEN1_IRQ1] & generator1_irq_in) |
        (route_r[`CTD_BIT_READY_A_IRQ1] & sample_ready_a_in) |
        (route_r[`CTD_BIT_READY_B_IRQ1] & sample_ready_b_in) |
        (route_r[`CTD_BIT_FILL_IRQ1] & fill_level_flag_in) |
        (route_r[`CTD_BIT_OVFL_IRQ1] &
         buffer_overflow_flag_in);
    end
  end

endmodule

//--- tb/ctd_host.sv
`timescale 1ns/10ps
// ****************************************
// Host side of the register port
// ****************************************
module ctd_host (
  // Bus to block
  input wire sys_clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task wr_reg(input [7:0] a, input [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  // Data valid at return, strobe clears source
  task rd_reg(input [7:0] a, input clr);
    @(negedge sys_clk_in);
    addr_out = a;
    rd_out = clr;
    @(negedge sys_clk_in);
    rd_out = 1'b0;
  endtask
endmodule

//--- tb/ctd_chk.sv
`timescale 1ns/10ps
module ctd_chk (
  // Watched ports
  input wire sys_clk_in,
  input wire rst_b_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire sample_strobe_in,
  input wire latch_click_interrupt_in,
  input wire generator1_irq_in,
  input wire sample_ready_a_in,
  input wire sample_ready_b_in,
  input wire fill_level_flag_in,
  input wire buffer_overflow_flag_in,
  input wire interrupt_pin_one_out,
  input wire click_irq_out
);
  reg [7:0] route_r;
  reg [7:0] cfg_r;
  wire any_w;
  assign any_w = rst_b_in & |({generator1_irq_in, sample_ready_a_in,
    sample_ready_b_in, fill_level_flag_in, buffer_overflow_flag_in} &
    {route_r[6], route_r[4:1]});
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      route_r <= 8'h00;
      cfg_r <= 8'h00;
    end else if (reg_wr_in && reg_addr_in == 8'h22) begin
      route_r <= reg_wdata_in & 8'hDE;
    end else if (reg_wr_in && reg_addr_in == 8'h38) begin
      cfg_r <= reg_wdata_in & 8'h3F;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Click irq up, latched, no source read last cycle
  sequence s_held_irq;
    click_irq_out && $past(latch_click_interrupt_in) &&
      !$past(reg_rd_in && reg_addr_in == 8'h39);
  endsequence
  // Click term already one register late on its own output
  chk_pin_or: assert property (
    interrupt_pin_one_out == ($past(any_w) ||
    ($past(route_r[7]) && click_irq_out))) else $error("pin not OR");
  chk_gen1_route: assert property (
    route_r[6] && generator1_irq_in |=> interrupt_pin_one_out)
    else $error("gen1 not routed");
  chk_route_read: assert property (
    $past(rst_b_in) && $past(reg_addr_in) == 8'h22 |->
    reg_rdata_out == $past(route_r)) else $error("route readback");
  chk_ths_width: assert property (
    $past(reg_addr_in) == 8'h3A |-> !reg_rdata_out[7])
    else $error("threshold bit7");
  chk_irq_sample: assert property (
    $rose(click_irq_out) |-> $past(sample_strobe_in, 2))
    else $error("click without sample");
  chk_click_cfg: assert property (
    $rose(click_irq_out) |-> $past(cfg_r) != 8'h00)
    else $error("click while disabled");
  chk_latch_hold: assert property (
    s_held_irq |=> click_irq_out)
    else $error("latched irq dropped");
  chk_reset_quiet: assert property (
    $rose(rst_b_in) |-> !interrupt_pin_one_out && !click_irq_out &&
    reg_rdata_out == 8'h00) else $error("outputs after reset");
endmodule
bind ctd_click_detector ctd_chk u_chk (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .sample_strobe_in(sample_strobe_in),
  .latch_click_interrupt_in(latch_click_interrupt_in),
  .generator1_irq_in(generator1_irq_in),
  .sample_ready_a_in(sample_ready_a_in),
  .sample_ready_b_in(sample_ready_b_in),
  .fill_level_flag_in(fill_level_flag_in),
  .buffer_overflow_flag_in(buffer_overflow_flag_in),
  .interrupt_pin_one_out(interrupt_pin_one_out),
  .click_irq_out(click_irq_out));

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic stb = 1'b0;
  logic latch = 1'b0;
  logic [15:0] ax1 = 16'h0000;
  logic [15:0] ax2 = 16'h0000;
  logic [15:0] ax3 = 16'h0000;
  logic [4:0] srcs = 5'h00;
  logic [31:0] lfsr = 32'h1C80;
  logic [7:0] ra[7] = '{8'h22, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h50};
  logic [8:0] q[$];
  wire wr, rd, pin, irq;
  wire [7:0] addr, wdata, rdata;
  int err_count = 0;
  int checked = 0;
  event look;
  always #2 clk = ~clk;
  ctd_host host (.sys_clk_in(clk), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  ctd_click_detector dut (.sys_clk_in(clk), .rst_b_in(rst_b),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .sample_strobe_in(stb),
    .axis1_in(ax1), .axis2_in(ax2), .axis3_in(ax3),
    .latch_click_interrupt_in(latch), .generator1_irq_in(srcs[4]),
    .sample_ready_a_in(srcs[3]), .sample_ready_b_in(srcs[2]),
    .fill_level_flag_in(srcs[1]), .buffer_overflow_flag_in(srcs[0]),
    .interrupt_pin_one_out(pin), .click_irq_out(irq));
  function automatic [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rd_exp(input [7:0] a, input clr, input [7:0] e);
    q.push_back({1'b0, e});
    host.rd_reg(a, clr);
    -> look;
  endtask
  // Pin and click interrupt, two negedges settle
  task out_exp(input [1:0] e);
    repeat (2) @(negedge clk);
    q.push_back({7'h40, e});
    -> look;
  endtask
  task smp(input [15:0] x, input [15:0] y);
    @(negedge clk);
    lfsr = lfsr_next(lfsr);
    ax1 = x;
    ax2 = y;
    ax3 = {8'h00, lfsr[7:0]};
    stb = 1'b1;
    @(negedge clk);
    stb = 1'b0;
  endtask
  task quiet(input int n);
    repeat (n) smp(16'h0000, 16'h0000);
  endtask
  // ****************************************
  // Result monitor
  // ****************************************
  initial begin
    logic [8:0] e;
    forever begin
      @(look);
      e = q.pop_front();
      chk(e[8] ? {6'h00, pin, irq} : rdata, e[7:0]);
    end
  end
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    foreach (ra[i]) rd_exp(ra[i], 1'b0, 8'h00);
    host.wr_reg(8'h3A, 8'hFF);
    rd_exp(8'h3A, 1'b0, 8'h7F);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      host.wr_reg(8'h22, lfsr[7:0]);
      srcs = lfsr[12:8];
      out_exp({|(srcs & {lfsr[6], lfsr[4:1]}), 1'b0});
    end
    srcs = 5'h00;
    latch = 1'b1;
    host.wr_reg(8'h3A, 8'h01);
    host.wr_reg(8'h3B, 8'h03);
    host.wr_reg(8'h3C, 8'h02);
    host.wr_reg(8'h3D, 8'h03);
    host.wr_reg(8'h22, 8'h80);
    host.wr_reg(8'h38, 8'h01);
    smp(16'h0200, 16'h0000);
    quiet(1);
    out_exp(2'b11);
    rd_exp(8'h39, 1'b1, 8'h51);
    out_exp(2'b00);
    host.wr_reg(8'h38, 8'h04);
    smp(16'h0000, 16'hFE00);
    quiet(1);
    rd_exp(8'h39, 1'b1, 8'h5A);
    // Held above past the limit, no restart while still above
    repeat (6) smp(16'h0000, 16'hFE00);
    quiet(1);
    rd_exp(8'h39, 1'b1, 8'h00);
    latch = 1'b0;
    smp(16'h0000, 16'h0300);
    quiet(1);
    out_exp(2'b11);
    quiet(4);
    out_exp(2'b00);
    rd_exp(8'h39, 1'b1, 8'h52);
    latch = 1'b1;
    host.wr_reg(8'h38, 8'h02);
    smp(16'h0200, 16'h0000);
    quiet(4);
    smp(16'h0200, 16'h0000);
    quiet(1);
    rd_exp(8'h39, 1'b1, 8'h61);
    smp(16'h0200, 16'h0000);
    quiet(12);
    smp(16'h0200, 16'h0000);
    quiet(1);
    rd_exp(8'h39, 1'b1, 8'h00);
    // Let window run out, then second click held over latency
    quiet(8);
    smp(16'h0200, 16'h0000);
    quiet(1);
    repeat (3) smp(16'h0200, 16'h0000);
    quiet(1);
    rd_exp(8'h39, 1'b1, 8'h61);
    // Both enables: first click reported as single
    host.wr_reg(8'h38, 8'h03);
    smp(16'h0200, 16'h0000);
    quiet(1);
    rd_exp(8'h39, 1'b1, 8'h51);
    end_sim;
  end
endmodule
